// ===== design/adcsr_defines.vh
// Register map, field positions and timing constants for the converter control
`ifndef ADCSR_DEFINES_VH
`define ADCSR_DEFINES_VH
// Register offsets (byte addresses)
`define ADCSR_OFS_INTCTL 8'h0b
`define ADCSR_OFS_PFLAGS 8'h0c
`define ADCSR_OFS_RES_HI 8'h1e
`define ADCSR_OFS_CTRL 8'h1f
`define ADCSR_OFS_PEN 8'h8c
`define ADCSR_OFS_RES_LO 8'h9e
`define ADCSR_OFS_PCFG 8'h9f
`define ADCSR_OFS_ISTAT 8'ha0
`define ADCSR_OFS_IMASK 8'ha4
`define ADCSR_OFS_CORE 8'ha8
// Control register fields
`define ADCSR_CLK_HI 7
`define ADCSR_CLK_LO 6
`define ADCSR_CHS_HI 5
`define ADCSR_CHS_LO 3
`define ADCSR_GO 2
`define ADCSR_PON 0
`define ADCSR_CLK_RC 2'h3
// Port config fields
`define ADCSR_JUST 7
`define ADCSR_PCFG_HI 3
`define ADCSR_PCFG_LO 0
`define ADCSR_PCFG_MASK 8'h8f
`define ADCSR_CTRL_MASK 8'hfd
// Flag and enable bit
`define ADCSR_DONE_BIT 6
`define ADCSR_PERIPHERAL_IRQ_ENABLE_BIT 6
`define ADCSR_GIE_BIT 7
// Interrupt status bits
`define ADCSR_EV_DONE 0
`define ADCSR_EV_ABORT 1
// Reset values
`define ADCSR_RST_BYTE 8'h00
`define ADCSR_RST_PINS 8'hff
// Timing
`define ADCSR_INSTR_NS 20
`define ADCSR_CLK_NS 5
`define ADCSR_CONV_CYC 12
`endif

// ===== design/adcsr_control.v
// Converter control block: registers, conversion sequencing, sleep, reset
`include "adcsr_defines.vh"
module adcsr_control #(
  parameter CONV_CYCLES = `ADCSR_CONV_CYC,
  parameter WAIT_NS = `ADCSR_INSTR_NS
) (
  // Clock and reset
  input wire clock,
  input wire rst_b,
  // Avalon-MM slave
  input wire [7:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output reg waitrequest,
  // Core and analog side
  input wire core_sleep,
  input wire [9:0] sample_value,
  output reg wake_request,
  output reg conv_power_up,
  output reg [2:0] channel_sel,
  output reg [7:0] analog_pins,
  output reg irq
);

  localparam WAIT_CYC_RAW = (WAIT_NS + `ADCSR_CLK_NS - 1) / `ADCSR_CLK_NS;
  localparam WAIT_CYC = (WAIT_CYC_RAW < 1) ? 1 : WAIT_CYC_RAW;

  localparam ST_IDLE = 4'b0001;
  localparam ST_WAIT = 4'b0010;
  localparam ST_CONV = 4'b0100;
  localparam ST_DONE = 4'b1000;

  //////////////////////////////////////////////////////////////////////////
  // Port configuration decode: one bit per channel, 1 = analog
  function [7:0] adcsr_analog_map;
    input [3:0] cfg;
    begin
      case (cfg)
        4'h0, 4'h1, 4'h8: adcsr_analog_map = 8'hff;
        4'h2, 4'h3: adcsr_analog_map = 8'h1f;
        4'h4, 4'h5: adcsr_analog_map = 8'h0b;
        4'h9, 4'ha, 4'hb: adcsr_analog_map = 8'h3f;
        4'hc: adcsr_analog_map = 8'h1f;
        4'hd: adcsr_analog_map = 8'h0f;
        4'he: adcsr_analog_map = 8'h01;
        4'hf: adcsr_analog_map = 8'h0d;
        default: adcsr_analog_map = 8'h00;
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  reg [1:0] conv_clock_select;
  reg [2:0] channel_select;
  reg go_busy;
  reg conv_power_on;
  reg result_justify;
  reg [3:0] port_config;
  reg [7:0] interrupt_control;
  reg [7:0] peripheral_enables;
  reg [7:0] peripheral_flags;
  reg [9:0] result;
  reg [1:0] irq_status;
  reg [1:0] irq_mask;
  reg [3:0] state;
  reg [15:0] count;
  reg sleep_meta;
  reg sleep_sync;
  reg [9:0] sample_meta;
  reg [9:0] sample_sync;

  wire is_rc = (conv_clock_select == `ADCSR_CLK_RC);
  wire bus_wr = write && waitrequest;
  wire bus_rd = read && waitrequest;
  wire wr_ctrl = bus_wr && (address == `ADCSR_OFS_CTRL);
  wire set_go = wr_ctrl && writedata[`ADCSR_GO] && writedata[`ADCSR_PON];
  wire done_ev = (state == ST_CONV) && (count == 16'd0);
  wire abort_ev = (state != ST_IDLE) && sleep_sync && !is_rc;
  wire [7:0] result_high_byte = result_justify ?
    {6'b000000, result[9:8]} : result[9:2];
  wire [7:0] result_low_byte = result_justify ?
    result[7:0] : {result[1:0], 6'b000000};
  wire [7:0] next_ctrl = {conv_clock_select, channel_select, go_busy,
    1'b0, conv_power_on};

  //////////////////////////////////////////////////////////////////////////
  // core_sleep and sample_value pass two flops before use
  always @(posedge clock) begin
    sleep_meta <= core_sleep;
    sleep_sync <= sleep_meta;
    sample_meta <= sample_value;
    sample_sync <= sample_meta;
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle, then answer
  always @(posedge clock) begin
    if (!rst_b) begin
      waitrequest <= 1'b1;
      readdata <= 32'h0000_0000;
    end else begin
      waitrequest <= !((read || write) && waitrequest);
      if (bus_rd) begin
        if (address == `ADCSR_OFS_CTRL)
          readdata <= {24'h00_0000, next_ctrl};
        else if (address == `ADCSR_OFS_PCFG)
          readdata <= {24'h00_0000, result_justify, 3'b000,
            port_config};
        else if (address == `ADCSR_OFS_RES_HI)
          readdata <= {24'h00_0000, result_high_byte};
        else if (address == `ADCSR_OFS_RES_LO)
          readdata <= {24'h00_0000, result_low_byte};
        else if (address == `ADCSR_OFS_INTCTL)
          readdata <= {24'h00_0000, interrupt_control};
        else if (address == `ADCSR_OFS_PFLAGS)
          readdata <= {24'h00_0000, peripheral_flags};
        else if (address == `ADCSR_OFS_PEN)
          readdata <= {24'h00_0000, peripheral_enables};
        else if (address == `ADCSR_OFS_ISTAT)
          readdata <= {30'h0000_0000, irq_status};
        else if (address == `ADCSR_OFS_IMASK)
          readdata <= {30'h0000_0000, irq_mask};
        else if (address == `ADCSR_OFS_CORE)
          readdata <= {27'h000_0000, state, conv_power_up};
        else
          readdata <= 32'h0000_0000;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registers and conversion sequencer
  always @(posedge clock) begin
    if (!rst_b) begin
      conv_clock_select <= 2'b00;
      channel_select <= 3'b000;
      go_busy <= 1'b0;
      conv_power_on <= 1'b0;
      result_justify <= 1'b0;
      port_config <= 4'h0;
      interrupt_control <= `ADCSR_RST_BYTE;
      peripheral_enables <= `ADCSR_RST_BYTE;
      peripheral_flags <= `ADCSR_RST_BYTE;
      irq_status <= 2'b00;
      irq_mask <= 2'b00;
      state <= ST_IDLE;
      count <= 16'd0;
    end else begin
      if (wr_ctrl) begin
        conv_clock_select <= writedata[`ADCSR_CLK_HI:`ADCSR_CLK_LO];
        channel_select <= writedata[`ADCSR_CHS_HI:`ADCSR_CHS_LO];
        conv_power_on <= writedata[`ADCSR_PON];
        go_busy <= writedata[`ADCSR_GO] & writedata[`ADCSR_PON];
      end
      if (bus_wr && address == `ADCSR_OFS_PCFG) begin
        result_justify <= writedata[`ADCSR_JUST];
        port_config <= writedata[`ADCSR_PCFG_HI:`ADCSR_PCFG_LO];
      end
      if (bus_wr && address == `ADCSR_OFS_INTCTL)
        interrupt_control <= writedata[7:0];
      if (bus_wr && address == `ADCSR_OFS_PEN)
        peripheral_enables <= writedata[7:0];
      if (bus_wr && address == `ADCSR_OFS_IMASK)
        irq_mask <= writedata[1:0];
      if (bus_wr && address == `ADCSR_OFS_PFLAGS)
        peripheral_flags <= writedata[7:0];
      if (bus_wr && address == `ADCSR_OFS_ISTAT)
        irq_status <= irq_status & ~writedata[1:0];
      case (state)
        ST_IDLE: begin
          if (set_go) begin
            state <= ST_WAIT;
            count <= is_rc ? WAIT_CYC[15:0] - 16'd1 : 16'd0;
          end
        end
        ST_WAIT: begin
          if (count == 16'd0) begin
            state <= ST_CONV;
            count <= CONV_CYCLES[15:0] - 16'd1;
          end else begin
            count <= count - 16'd1;
          end
        end
        ST_CONV: begin
          if (count != 16'd0)
            count <= count - 16'd1;
          else
            state <= ST_DONE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
      if (done_ev) begin
        go_busy <= 1'b0;
        result <= sample_sync;
        peripheral_flags[`ADCSR_DONE_BIT] <= 1'b1;
      end
      if (abort_ev) begin
        state <= ST_IDLE;
        go_busy <= 1'b0;
      end
      if (wr_ctrl && !writedata[`ADCSR_PON] && !set_go)
        state <= ST_IDLE;
      // Hardware set wins over write-one-to-clear
      if (done_ev)
        irq_status[`ADCSR_EV_DONE] <= 1'b1;
      if (abort_ev)
        irq_status[`ADCSR_EV_ABORT] <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always @(posedge clock) begin
    if (!rst_b) begin
      wake_request <= 1'b0;
      conv_power_up <= 1'b0;
      channel_sel <= 3'b000;
      analog_pins <= `ADCSR_RST_PINS;
      irq <= 1'b0;
    end else begin
      wake_request <= sleep_sync && done_ev &&
        peripheral_enables[`ADCSR_DONE_BIT];
      // Analog powered off in sleep unless RC is running it
      conv_power_up <= conv_power_on && (!sleep_sync || is_rc);
      channel_sel <= channel_select;
      analog_pins <= adcsr_analog_map(port_config);
      irq <= |(irq_status & irq_mask);
    end
  end

endmodule

// ===== tb/adcsr_sva.sv
// Port assertions for the converter control block
module adcsr_sva (
  // Clock and reset
  input wire clock,
  input wire rst_b,
  // Register bus
  input wire [7:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [31:0] readdata,
  input wire waitrequest,
  // Core side
  input wire core_sleep,
  input wire wake_request,
  input wire conv_power_up,
  input wire [2:0] channel_sel,
  input wire [7:0] analog_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  // Shadows go stale over reset; that only makes checks vacuous
  reg [7:0] wd;
  reg [1:0] cs;
  always @(posedge clock) begin
    if (write && !waitrequest) wd <= writedata[7:0];
    if (write && !waitrequest && address == 8'h1f) cs <= writedata[7:6];
  end
  sequence s_wr(a);
    write && !waitrequest && address == a;
  endsequence
  sequence s_rd(a);
    read && !waitrequest && address == a;
  endsequence
  sequence s_nap;
    $rose(core_sleep) && cs != 2'h3;
  endsequence
  a_bus_ack:
    assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("no answer");
  a_reset_vals:
    assert property ($rose(rst_b) |-> analog_pins == 8'hff
      && !conv_power_up && !wake_request) else $error("reset state");
  a_wake_pulse:
    assert property (wake_request |=> !wake_request) else $error("wake");
  a_sleep_abort:
    assert property (s_nap |-> ##[1:6] !conv_power_up)
    else $error("no power down");
  a_chan_copy:
    assert property (s_wr(8'h1f) |-> ##[1:2] channel_sel == wd[5:3])
    else $error("channel");
  a_ctl_read:
    assert property (s_rd(8'h1f) |-> readdata[31:8] == 0 && !readdata[1])
    else $error("control bits");
  a_cfg_read:
    assert property (s_rd(8'h9f) |-> readdata[31:8] == 0
      && readdata[6:4] == 0) else $error("config bits");
  a_cfg_pins:
    assert property (s_wr(8'h9f) |-> ##[1:2] analog_pins == (wd[3:1] ==
      3'h3 ? 8'h00 : wd[3:0] == 4'h0 ? 8'hff : analog_pins))
    else $error("pins");
endmodule
bind adcsr_control adcsr_sva adcsr_sva_inst (.clock(clock), .rst_b(rst_b),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest), .core_sleep(core_sleep),
  .wake_request(wake_request), .conv_power_up(conv_power_up),
  .channel_sel(channel_sel), .analog_pins(analog_pins));

// ===== tb/adcsr_core_model.sv
// Core and analog side: sleeps on command, leaves sleep on wake
module adcsr_core_model (
  // Clock and commands
  input wire clock,
  input wire go_sleep,
  input wire force_wake,
  input wire [9:0] level,
  // Block side
  input wire wake_request,
  output logic core_sleep = 0,
  output logic [9:0] sample_value = 0,
  output int wakes = 0
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge clock) begin
    sample_value <= level;
    if (wake_request) wakes <= wakes + 1;
    if (go_sleep) core_sleep <= 1;
    else if (wake_request || force_wake) core_sleep <= 0;
  end
endmodule

// ===== tb/adcsr_control_tb.sv
// Self-checking bench for the converter control block
module adcsr_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, rst_b = 0, read = 0, write = 0;
  logic go_sleep = 0, force_wake = 0;
  logic [7:0] address = 0;
  logic [7:0] ra[5] = '{8'h1f, 8'h9f, 8'h0c, 8'h8c, 8'h50};
  logic [31:0] writedata = 0, rv;
  logic [31:0] eq[$], mq[$];
  logic [9:0] level = 0, s;
  logic [2:0] c;
  wire [31:0] readdata;
  wire [9:0] sample_value;
  wire [7:0] analog_pins;
  wire [2:0] channel_sel;
  wire waitrequest, wake_request, conv_power_up, irq, core_sleep;
  int wakes, j, k, mismatches = 0, n_compared = 0, seed = 32'hce2b;
  always #2.5 clock = ~clock;
  adcsr_control adcsr_control_inst (.clock(clock), .rst_b(rst_b),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
    .core_sleep(core_sleep), .sample_value(sample_value),
    .wake_request(wake_request), .conv_power_up(conv_power_up),
    .channel_sel(channel_sel), .analog_pins(analog_pins));
  adcsr_core_model adcsr_core_model_inst (.clock(clock), .level(level),
    .go_sleep(go_sleep), .force_wake(force_wake), .wakes(wakes),
    .wake_request(wake_request), .core_sleep(core_sleep),
    .sample_value(sample_value));
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] v);
    n_compared++;
    if (e !== v) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, v);
    end
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    int i;
    @(posedge clock);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    for (i = 0; i < 20 && waitrequest !== 1'b0; i++) @(posedge clock);
    rv = readdata;
    write <= 0;
    read <= 0;
    if (i == 20) mismatches++;
    if (i == 20) summarize();
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m);
    eq.push_back(e & m);
    mq.push_back(m);
    bus(0, a, 0);
  endtask
  // Read data are only valid at the answering edge
  always @(posedge clock)
    if (read && waitrequest === 1'b0 && eq.size() > 0)
      chk("readdata", eq.pop_front(), readdata & mq.pop_front());
  task automatic res(logic jr);
    rd(8'h1e, jr ? s[9:8] : s[9:2], 8'hff);
    rd(8'h9e, jr ? s[7:0] : {s[1:0], 6'h0}, 8'hff);
  endtask
  task automatic poke(logic z, int n);
    {go_sleep, force_wake} <= z ? 2'b10 : 2'b01;
    @(posedge clock);
    {go_sleep, force_wake} <= 2'b00;
    repeat (n) @(posedge clock);
  endtask
  initial begin
    repeat (3) @(posedge clock);
    rst_b <= 1;
    foreach (ra[i]) rd(ra[i], 0, 32'hffff_ffff);
    chk("analog_pins", 8'hff, analog_pins);
    bus(1, 8'h9f, 8'hff);
    rd(8'h9f, 8'h8f, 32'hffff_ffff);
    for (j = 0; j < 2; j++) begin
      s = $random(seed);
      c = $random(seed);
      level <= s;
      bus(1, 8'h9f, {j[0], 7'h06});
      bus(1, 8'h0c, 0);
      bus(1, 8'h1f, {2'h1, c, 3'h5});
      rv = 32'h0000_0004;
      for (k = 0; k < 30 && rv[2] !== 1'b0; k++) rd(8'h1f, 0, 0);
      if (k == 30) begin
        mismatches++;
        summarize();
      end
      rd(8'h1f, {2'h1, c, 3'h1}, 8'hff);
      res(j[0]);
      rd(8'h0c, 8'h40, 8'h40);
      chk("channel_sel", c, channel_sel);
      chk("analog_pins", 0, analog_pins);
    end
    chk("irq", 0, irq);
    bus(1, 8'ha4, 1);
    poke(1'b0, 2);
    chk("irq", 1, irq);
    bus(1, 8'ha0, 1);
    poke(1'b0, 2);
    chk("irq", 0, irq);
    // Sleep straight after go, wake enabled, then disabled
    for (j = 0; j < 2; j++) begin
      bus(1, 8'h8c, j ? 8'h00 : 8'h40);
      bus(1, 8'h0c, 0);
      bus(1, 8'h1f, 8'hc5);
      poke(1'b1, 60);
      chk("wakes", 1, wakes);
      chk("core_sleep", j, core_sleep);
      poke(1'b0, 4);
      rd(8'h1f, 8'hc1, 8'hff);
      rd(8'h0c, 8'h40, 8'h40);
      res(1);
    end
    bus(1, 8'h0c, 0);
    level <= ~s;
    bus(1, 8'h1f, 8'h45);
    poke(1'b1, 8);
    chk("conv_power_up", 0, conv_power_up);
    poke(1'b0, 4);
    rd(8'h1f, 8'h41, 8'hff);
    rd(8'h0c, 0, 8'h40);
    res(1);
    bus(1, 8'h1f, 8'h45);
    rst_b <= 0;
    @(posedge clock);
    rst_b <= 1;
    rd(8'h1f, 0, 8'hff);
    res(0);
    chk("analog_pins", 8'hff, analog_pins);
    summarize();
  end
endmodule
